/* File: core/uifc_map.vh */
`ifndef UIFC_MAP_VH
`define UIFC_MAP_VH

// ************************************************************
// register offsets on the three-bit port address
// ************************************************************
`define UIFC_OFS_DATA 3'h0
`define UIFC_OFS_IEN 3'h1
`define UIFC_OFS_IDENT 3'h2
`define UIFC_OFS_LSTAT 3'h5
`define UIFC_OFS_MSTAT 3'h6

// ************************************************************
// interrupt enable fields
// ************************************************************
`define UIFC_IEN_RXDATA 0
`define UIFC_IEN_TXEMPTY 1
`define UIFC_IEN_LSTAT 2
`define UIFC_IEN_MSTAT 3
`define UIFC_IEN_RESET 4'h0
`define UIFC_IEN_PAD 4'h0

// ************************************************************
// fifo control fields
// ************************************************************
`define UIFC_FC_ENABLE 0
`define UIFC_FC_RXRST 1
`define UIFC_FC_TXRST 2
`define UIFC_FC_TRIG_HI 7
`define UIFC_FC_TRIG_LO 6
`define UIFC_TRIG_RESET 2'h0

// ************************************************************
// identification codes in bits 3:0, upper fields and reset value
// ************************************************************
`define UIFC_ID_NONE 4'h1
`define UIFC_ID_LSTAT 4'h6
`define UIFC_ID_RXDATA 4'h4
`define UIFC_ID_TIMEOUT 4'hc
`define UIFC_ID_TXEMPTY 4'h2
`define UIFC_ID_MSTAT 4'h0
`define UIFC_ID_RSVD 2'h0
`define UIFC_ID_FIFO_ON 2'h3
`define UIFC_ID_FIFO_OFF 2'h0
`define UIFC_IDENT_RESET 8'h01

// ************************************************************
// receive trigger levels in bytes
// ************************************************************
`define UIFC_TRIG_SEL0 5'h01
`define UIFC_TRIG_SEL1 5'h04
`define UIFC_TRIG_SEL2 5'h08
`define UIFC_TRIG_SEL3 5'h0e

// ************************************************************
// timeout: character times and baud ticks per bit
// ************************************************************
`define UIFC_CHAR_TIMES 4
`define UIFC_OVERSAMPLE 16

`endif

/* File: core/uifc_prio.v */
`timescale 1ns/10ps
`include "uifc_map.vh"

// ************************************************************
// fixed-priority selection of the reported interrupt
// ************************************************************
module uifc_prio (
  input wire ls_act,
  input wire rda_act,
  input wire to_act,
  input wire thre_act,
  input wire ms_act,
  output reg [3:0] id_code
);

  // line status first, modem status last
  always @* begin
    if (ls_act) begin
      id_code = `UIFC_ID_LSTAT;
    end else if (rda_act) begin
      id_code = `UIFC_ID_RXDATA;
    end else if (to_act) begin
      id_code = `UIFC_ID_TIMEOUT;
    end else if (thre_act) begin
      id_code = `UIFC_ID_TXEMPTY;
    end else if (ms_act) begin
      id_code = `UIFC_ID_MSTAT;
    end else begin
      id_code = `UIFC_ID_NONE;
    end
  end

endmodule

/* File: core/uifc_timeout.v */
`timescale 1ns/10ps
`include "uifc_map.vh"

// ************************************************************
// receive character timeout
// ************************************************************
module uifc_timeout #(
  parameter CNT_W = 10
) (
  input wire clock,
  input wire rst_n,
  input wire active,
  input wire fifo_move,
  input wire baud_tick,
  input wire [3:0] frame_bits,
  input wire clear,
  output reg pend_r
);

  localparam [31:0] MULT_FULL = `UIFC_CHAR_TIMES * `UIFC_OVERSAMPLE;
  localparam [CNT_W-1:0] MULT = MULT_FULL[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] limit;

  // limit follows the live frame length, so a format change re-times it
  assign limit = {{(CNT_W-4){1'b0}}, frame_bits} * MULT;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (!active || fifo_move) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (baud_tick && cnt_r != limit) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if (active && baud_tick && cnt_r + 1'b1 == limit) begin
      pend_r <= 1'b1;
    end else if (clear || !active) begin
      pend_r <= 1'b0;
    end
  end

endmodule

/* File: core/uifc_top.v */
`timescale 1ns/10ps
`include "uifc_map.vh"

module uifc_top #(
  parameter LVL_W = 5,
  parameter TO_W = 10
) (
  input wire clock,
  input wire rst_n,
  input wire [2:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  input wire divisor_latch_access,
  input wire interrupt_output_gate,
  input wire line_error_event,
  input wire modem_change_event,
  input wire tx_empty_event,
  input wire rx_data_ready,
  input wire [LVL_W-1:0] rx_fifo_level,
  input wire rx_push,
  input wire rx_pop,
  input wire baud_tick,
  input wire [3:0] frame_bits,
  output reg port_irq,
  output reg fifo_enable,
  output reg [1:0] rx_trigger_sel,
  output reg receive_side_flush,
  output reg transmit_side_flush
);

  // ************************************************************
  // helpers
  // ************************************************************
  function [LVL_W-1:0] trig_bytes;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: trig_bytes = `UIFC_TRIG_SEL0;
        2'h1: trig_bytes = `UIFC_TRIG_SEL1;
        2'h2: trig_bytes = `UIFC_TRIG_SEL2;
        default: trig_bytes = `UIFC_TRIG_SEL3;
      endcase
    end
  endfunction

  // ************************************************************
  // access decode
  // ************************************************************
  wire ien_sel;
  wire ien_wr;
  wire ident_rd;
  wire fc_wr;
  wire data_rd;
  wire data_wr;
  wire lstat_rd;
  wire mstat_rd;

  assign ien_sel = (bus_addr == `UIFC_OFS_IEN) && !divisor_latch_access;
  assign ien_wr = bus_wr && ien_sel;
  // the shared offset ignores the latch flag in both directions
  assign ident_rd = bus_rd && (bus_addr == `UIFC_OFS_IDENT);
  assign fc_wr = bus_wr && (bus_addr == `UIFC_OFS_IDENT);
  assign data_rd = bus_rd && (bus_addr == `UIFC_OFS_DATA) && !divisor_latch_access;
  assign data_wr = bus_wr && (bus_addr == `UIFC_OFS_DATA) && !divisor_latch_access;
  assign lstat_rd = bus_rd && (bus_addr == `UIFC_OFS_LSTAT);
  assign mstat_rd = bus_rd && (bus_addr == `UIFC_OFS_MSTAT);

  // ************************************************************
  // interrupt enable register
  // ************************************************************
  reg [3:0] ien_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ien_r <= `UIFC_IEN_RESET;
    end else if (ien_wr) begin
      // upper nibble is not stored at all
      ien_r <= bus_wdata[3:0];
    end
  end

  // ************************************************************
  // fifo control register
  // ************************************************************
  wire fc_on;

  assign fc_on = bus_wdata[`UIFC_FC_ENABLE];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fifo_enable <= 1'b0;
    end else if (fc_wr) begin
      fifo_enable <= fc_on;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_trigger_sel <= `UIFC_TRIG_RESET;
    end else if (fc_wr && fc_on) begin
      // a write with bit 0 low leaves the trigger untouched
      rx_trigger_sel <= bus_wdata[`UIFC_FC_TRIG_HI:`UIFC_FC_TRIG_LO];
    end
  end

  // flush strobes are one-cycle pulses, so the control bits self-clear
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      receive_side_flush <= 1'b0;
    end else begin
      receive_side_flush <= fc_wr && ((fc_on && bus_wdata[`UIFC_FC_RXRST]) ||
                            (fc_on != fifo_enable));
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transmit_side_flush <= 1'b0;
    end else begin
      transmit_side_flush <= fc_wr && ((fc_on && bus_wdata[`UIFC_FC_TXRST]) ||
                             (fc_on != fifo_enable));
    end
  end

  // ************************************************************
  // interrupt sources
  // ************************************************************
  reg ls_pend_r;
  reg thre_pend_r;
  reg ms_pend_r;
  reg [3:0] ident_r;
  wire to_pend;
  wire rda_level;
  wire thre_clear;

  // set beats clear so an error in the read cycle is kept
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ls_pend_r <= 1'b0;
    end else if (line_error_event) begin
      ls_pend_r <= 1'b1;
    end else if (lstat_rd) begin
      ls_pend_r <= 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_pend_r <= 1'b0;
    end else if (modem_change_event) begin
      ms_pend_r <= 1'b1;
    end else if (mstat_rd) begin
      ms_pend_r <= 1'b0;
    end
  end

  // the frozen code decides, so a later event cannot be swallowed
  assign thre_clear = data_wr || (ident_rd && ident_r == `UIFC_ID_TXEMPTY);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thre_pend_r <= 1'b0;
    end else if (tx_empty_event) begin
      thre_pend_r <= 1'b1;
    end else if (thre_clear) begin
      thre_pend_r <= 1'b0;
    end
  end

  // level based: a buffer read lowers the level and drops it
  assign rda_level = fifo_enable ? (rx_fifo_level >= trig_bytes(rx_trigger_sel)) :
                     rx_data_ready;

  uifc_timeout #(
    .CNT_W(TO_W)
  ) u_timeout (
    .clock(clock),
    .rst_n(rst_n),
    .active(fifo_enable && rx_fifo_level != {LVL_W{1'b0}}),
    .fifo_move(rx_push || rx_pop),
    .baud_tick(baud_tick),
    .frame_bits(frame_bits),
    .clear(data_rd),
    .pend_r(to_pend)
  );

  // ************************************************************
  // priority and identification
  // ************************************************************
  wire [3:0] id_code;
  wire any_act;
  wire ls_act;
  wire rda_act;
  wire to_act;
  wire thre_act;
  wire ms_act;

  assign ls_act = ls_pend_r && ien_r[`UIFC_IEN_LSTAT];
  assign rda_act = rda_level && ien_r[`UIFC_IEN_RXDATA];
  assign to_act = to_pend && fifo_enable && ien_r[`UIFC_IEN_RXDATA];
  assign thre_act = thre_pend_r && ien_r[`UIFC_IEN_TXEMPTY];
  assign ms_act = ms_pend_r && ien_r[`UIFC_IEN_MSTAT];
  assign any_act = ls_act || rda_act || to_act || thre_act || ms_act;

  uifc_prio u_prio (
    .ls_act(ls_act),
    .rda_act(rda_act),
    .to_act(to_act),
    .thre_act(thre_act),
    .ms_act(ms_act),
    .id_code(id_code)
  );

  // frozen during the read; new events show from the next cycle on
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ident_r <= `UIFC_ID_NONE;
    end else if (!ident_rd) begin
      ident_r <= id_code;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    if (ident_rd) begin
      // a timeout code latched just before the fifos went off must not show bit 3
      rdata_nxt = {(fifo_enable ? `UIFC_ID_FIFO_ON : `UIFC_ID_FIFO_OFF),
                   `UIFC_ID_RSVD, (ident_r[3] && fifo_enable), ident_r[2:0]};
    end else if (bus_rd && ien_sel) begin
      rdata_nxt = {`UIFC_IEN_PAD, ien_r};
    end
  end

  // other offsets belong to neighbouring registers and read zero here
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rdata_nxt;
    end
  end

  // ************************************************************
  // port interrupt
  // ************************************************************
  // follows the live sources one cycle later, not the frozen code, so a read never holds it back
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= any_act && interrupt_output_gate;
    end
  end

endmodule

/* File: verification/uifc_props.sv */
`timescale 1ns/10ps
// ********************
// port level checks
// ********************
module uifc_props (
  input wire clock,
  input wire rst_n,
  input wire [2:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire divisor_latch_access,
  input wire interrupt_output_gate,
  input wire port_irq,
  input wire fifo_enable,
  input wire [1:0] rx_trigger_sel,
  input wire receive_side_flush,
  input wire transmit_side_flush
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire fc_wr = bus_wr && bus_addr == 3'h2;
  wire id_rd = bus_rd && bus_addr == 3'h2;
  a_gate_low:
    assert property (!interrupt_output_gate |=> !port_irq)
    else $error("port irq high with gate low");
  a_fifo_enable:
    assert property (fc_wr |=> fifo_enable == $past(bus_wdata[0]))
    else $error("fifo enable not taken from write");
  a_off_flush:
    assert property (fc_wr && fifo_enable && !bus_wdata[0] |=> receive_side_flush &&
      transmit_side_flush)
    else $error("disable did not flush both");
  a_trig_sel:
    assert property (fc_wr |=> rx_trigger_sel == ($past(bus_wdata[0]) ?
      $past(bus_wdata[7:6]) : $past(rx_trigger_sel)))
    else $error("trigger select wrong");
  a_rx_flush:
    assert property (fc_wr && bus_wdata[1:0] == 2'h3 ##1 !bus_wr |->
      receive_side_flush ##1 !receive_side_flush)
    else $error("rx flush not one pulse");
  a_tx_flush:
    assert property (fc_wr && bus_wdata[2] && bus_wdata[0] ##1 !bus_wr |->
      transmit_side_flush ##1 !transmit_side_flush)
    else $error("tx flush not one pulse");
  a_ien_off:
    assert property (bus_wr && bus_addr == 3'h1 && !divisor_latch_access &&
      bus_wdata[3:0] == 4'h0 ##1 !bus_wr [*3] |-> !port_irq)
    else $error("irq with all enables clear");
  a_ien_pad:
    assert property (bus_rd && bus_addr == 3'h1 |=> bus_rdata[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  a_ident_pad:
    assert property (id_rd |=> bus_rdata[5:4] == 2'h0 &&
      bus_rdata[7:6] == {2{$past(fifo_enable)}})
    else $error("ident upper bits wrong");
  a_ident_code:
    assert property (id_rd |=> bus_rdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hc}
      && (!bus_rdata[3] || $past(fifo_enable)))
    else $error("ident code illegal");
  c_timeout: cover property (id_rd ##1 bus_rdata[3:0] == 4'hc);
  c_line: cover property (id_rd ##1 bus_rdata[3:0] == 4'h6);
  c_irq: cover property ($rose(port_irq));
endmodule
bind uifc_top uifc_props i_props (.clock, .rst_n, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
  .bus_rdata, .divisor_latch_access, .interrupt_output_gate, .port_irq, .fifo_enable,
  .rx_trigger_sel, .receive_side_flush, .transmit_side_flush);

/* File: verification/uifc_host.sv */
`timescale 1ns/10ps
// ********************
// host side of the register port
// ********************
module uifc_host (
  input wire clock,
  input wire [7:0] bus_rdata,
  output reg [2:0] bus_addr,
  output reg bus_rd,
  output reg bus_wr,
  output reg [7:0] bus_wdata
);
  initial begin
    bus_addr = 3'h0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // released data shows the inverse so a stale byte is never mistaken for a live one
  task wr(input [2:0] a, input [7:0] v);
    begin
      @(negedge clock);
      bus_addr = a;
      bus_wdata = v;
      bus_wr = 1'b1;
      @(negedge clock);
      bus_wr = 1'b0;
      bus_wdata = ~v;
    end
  endtask
  task rd(input [2:0] a, output [7:0] v);
    begin
      @(negedge clock);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clock);
      bus_rd = 1'b0;
      @(negedge clock);
      v = bus_rdata;
    end
  endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
// ********************
// testbench
// ********************
module tb;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  wire [2:0] bus_addr;
  wire bus_rd;
  wire bus_wr;
  wire [7:0] bus_wdata;
  wire [7:0] bus_rdata;
  reg divisor_latch_access = 1'b0;
  reg interrupt_output_gate = 1'b0;
  reg line_error_event = 1'b0;
  reg modem_change_event = 1'b0;
  reg tx_empty_event = 1'b0;
  reg rx_data_ready = 1'b0;
  reg [4:0] rx_fifo_level = 5'h00;
  reg rx_push = 1'b0;
  reg rx_pop = 1'b0;
  reg baud_tick = 1'b0;
  reg [3:0] frame_bits = 4'h2;
  wire port_irq;
  wire fifo_enable;
  wire [1:0] rx_trigger_sel;
  wire receive_side_flush;
  wire transmit_side_flush;
  integer num_errors = 0;
  integer checks_done = 0;
  integer n_rxf = 0;
  integer n_txf = 0;
  reg [7:0] d;
  uifc_top i_dut (.clock, .rst_n, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
    .divisor_latch_access, .interrupt_output_gate, .line_error_event, .modem_change_event,
    .tx_empty_event, .rx_data_ready, .rx_fifo_level, .rx_push, .rx_pop, .baud_tick,
    .frame_bits, .port_irq, .fifo_enable, .rx_trigger_sel, .receive_side_flush,
    .transmit_side_flush);
  uifc_host i_host (.clock, .bus_rdata, .bus_addr, .bus_rd, .bus_wr, .bus_wdata);
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    n_rxf <= n_rxf + receive_side_flush;
    n_txf <= n_txf + transmit_side_flush;
  end
  task finish_test;
    begin
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string w, input [7:0] e, input [7:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value %s expected %h seen %h", w, e, g);
      end
    end
  endtask
  task rdc(input [2:0] a, input [7:0] e, input string w);
    begin
      i_host.rd(a, d);
      chk(w, e, d);
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // pending sources and the code register each need an edge, so allow a margin
  task ev(input [2:0] m);
    begin
      {line_error_event, modem_change_event, tx_empty_event} = m;
      wait_n(1);
      {line_error_event, modem_change_event, tx_empty_event} = 3'h0;
      wait_n(3);
    end
  endtask
  task t_ien;
    begin
      rdc(3'h2, 8'h01, "ident reset");
      i_host.wr(3'h1, 8'hff);
      rdc(3'h1, 8'h0f, "enable");
      divisor_latch_access = 1'b1;
      i_host.wr(3'h1, 8'h00);
      rdc(3'h1, 8'h00, "enable hidden");
      divisor_latch_access = 1'b0;
      rdc(3'h1, 8'h0f, "enable kept");
    end
  endtask
  task t_prio;
    begin
      interrupt_output_gate = 1'b1;
      ev(3'h7);
      rx_data_ready = 1'b1;
      wait_n(3);
      rdc(3'h2, 8'h06, "line first");
      chk("irq on", 8'h01, {7'h0, port_irq});
      i_host.rd(3'h5, d);
      wait_n(3);
      rdc(3'h2, 8'h04, "data second");
      rx_data_ready = 1'b0;
      wait_n(3);
      rdc(3'h2, 8'h02, "tx third");
      wait_n(3);
      rdc(3'h2, 8'h00, "modem last");
      interrupt_output_gate = 1'b0;
      wait_n(3);
      chk("irq gated", 8'h00, {7'h0, port_irq});
      i_host.rd(3'h6, d);
      wait_n(3);
      rdc(3'h2, 8'h01, "modem cleared");
      ev(3'h1);
      i_host.wr(3'h0, 8'h55);
      wait_n(3);
      rdc(3'h2, 8'h01, "tx written");
    end
  endtask
  task t_off;
    begin
      i_host.wr(3'h1, 8'h00);
      interrupt_output_gate = 1'b1;
      ev(3'h7);
      rdc(3'h2, 8'h01, "all off");
      chk("irq off", 8'h00, {7'h0, port_irq});
      i_host.rd(3'h5, d);
      i_host.rd(3'h6, d);
      i_host.wr(3'h0, 8'h00);
    end
  endtask
  task t_fifo;
    integer i;
    integer r0;
    integer t0;
    reg [4:0] lv;
    begin
      i_host.wr(3'h1, 8'h01);
      i_host.wr(3'h2, 8'hc7);
      chk("fifo on", 8'h01, {7'h0, fifo_enable});
      rdc(3'h2, 8'hc1, "ident fifo");
      r0 = n_rxf;
      t0 = n_txf;
      i_host.wr(3'h2, 8'h03);
      wait_n(2);
      chk("rx flush", 8'h01, 8'(n_rxf - r0));
      chk("tx flush", 8'h00, 8'(n_txf - t0));
      for (i = 0; i < 4; i = i + 1) begin
        lv = (i == 0) ? 5'h01 : (i == 1) ? 5'h04 : (i == 2) ? 5'h08 : 5'h0e;
        i_host.wr(3'h2, {i[1:0], 6'h01});
        chk("trigger", {6'h0, i[1:0]}, {6'h0, rx_trigger_sel});
        rx_fifo_level = lv - 5'h01;
        wait_n(3);
        rdc(3'h2, 8'hc1, "below trigger");
        rx_fifo_level = lv;
        wait_n(3);
        rdc(3'h2, 8'hc4, "at trigger");
      end
      rx_fifo_level = 5'h00;
      r0 = n_rxf;
      t0 = n_txf;
      i_host.wr(3'h2, 8'h40);
      wait_n(2);
      chk("fifo off", 8'h00, {7'h0, fifo_enable});
      chk("trigger kept", 8'h03, {6'h0, rx_trigger_sel});
      chk("off flush", 8'h02, 8'(n_rxf - r0 + n_txf - t0));
    end
  endtask
  task t_timeout;
    begin
      i_host.wr(3'h2, 8'hc1);
      rx_fifo_level = 5'h01;
      baud_tick = 1'b1;
      repeat (2) begin
        rx_push = 1'b1;
        wait_n(1);
        rx_push = 1'b0;
        wait_n(100);
      end
      rdc(3'h2, 8'hc1, "no timeout");
      wait_n(40);
      rdc(3'h2, 8'hcc, "timeout");
      i_host.rd(3'h0, d);
      wait_n(2);
      rdc(3'h2, 8'hc1, "timeout read");
      rx_pop = 1'b1;
      rx_fifo_level = 5'h00;
      wait_n(1);
      rx_pop = 1'b0;
      wait_n(3);
      rdc(3'h2, 8'hc1, "timeout cleared");
      baud_tick = 1'b0;
    end
  endtask
  initial begin
    #80000;
    num_errors = num_errors + 1;
    finish_test;
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_ien;
    t_prio;
    t_off;
    t_fifo;
    t_timeout;
    finish_test;
  end
endmodule
